/* File: bench/flow_acc_sva.sv */
// Port checker for the flow data accumulator.
// Assumes one clock domain and the top module's ports only.
`timescale 1ns/1ps
module flow_acc_sva
	import flow_acc_pkg::*;
(
	// Clock and reset
	input logic clk,
	input logic resetn,
	// Variant and host side
	input logic singleHead,
	input host_req_s hostReq,
	input host_ans_s hostAns,
	// Flow stream
	input flow_item_s item,
	input logic itemValid,
	input logic itemLast,
	input logic itemReady
);
	// Decoded flow-unit writes, cycle reads and area reads
	wire wr = hostReq.valid && hostReq.kind == CMD_PARAM_WRITE && hostReq.unitNo == FLOW_UNIT;
	wire [31:0] wd = hostReq.wdata;
	wire [7:0] dn = hostReq.dataNo;
	wire cyc = hostReq.valid && hostReq.kind == CMD_PARAM_READ && hostReq.unitNo == SYS_UNIT;
	wire badArea = hostReq.valid && hostReq.kind == CMD_AREA_READ;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_ack_next_cycle: assert property (hostReq.valid |=> hostAns.ack)
		else $error("ack missing after request");
	a_no_stray_ack: assert property (!hostReq.valid |=> !hostAns.ack)
		else $error("ack without request");
	a_enable_range: assert property (wr && dn == DATA_ENABLE && wd > 32'h1 |=> hostAns.err)
		else $error("enable above one accepted");
	a_interval_range: assert property (wr && dn == DATA_INTERVAL &&
		(wd == 32'h0 || wd > MAX_INTERVAL) |=> hostAns.err) else $error("bad interval accepted");
	a_depth_range: assert property (wr && dn == DATA_DEPTH &&
		(wd == 32'h0 || wd > MAX_DEPTH) |=> hostAns.err) else $error("bad depth accepted");
	a_single_slots: assert property (wr && singleHead && dn > DATA_SLOT_LAST_SINGLE &&
		dn <= DATA_SLOT_LAST |=> hostAns.err) else $error("missing slot accepted");
	a_area_code: assert property (badArea && hostReq.areaCode != FLOW_AREA_CODE
		|=> hostAns.err) else $error("wrong area code accepted");
	a_normal_cycle: assert property (cyc && dn == DATA_CYCLE && !singleHead
		|=> hostAns.rdata == NORMAL_CYCLE_US) else $error("wrong cycle value");
	a_item_held: assert property (itemValid && !itemReady |=> itemValid && $stable(item))
		else $error("item dropped before acceptance");
	a_item_gap: assert property (itemValid && itemReady |=> !itemValid [*2])
		else $error("item repeated too soon");
	a_last_valid: assert property (itemLast |-> itemValid)
		else $error("last flag without item");
	a_header_bits: assert property (itemValid |-> item.header[HDR_STOP_BIT] &&
		(item.header & 32'hff3f_fbff) == 32'h0) else $error("bad header layout");
endmodule

bind flow_data_accumulator flow_acc_sva i_sva (.clk(clk), .resetn(resetn),
	.singleHead(singleHead), .hostReq(hostReq), .hostAns(hostAns), .item(item),
	.itemValid(itemValid), .itemLast(itemLast), .itemReady(itemReady));

/* File: bench/flow_data_accumulator_test.sv */
// Self-checking bench for the flow data accumulator.
// Assumes the checker is bound in and short timer periods are set here.
`timescale 1ns/1ps
module flow_data_accumulator_test
	import flow_acc_pkg::*;
;
	localparam int NP = 125;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic singleHead = 1'b1;
	logic highSpeed = 1'b1;
	logic filmMode = 1'b1;
	meas_s measIn = '0;
	host_req_s hostReq;
	host_ans_s hostAns;
	flow_item_s item;
	logic itemValid, itemLast, itemReady, bufferOverflow;
	int fails = 0;
	int nCompared = 0;
	int cycles = 0;
	int tFirst = 0;
	host_ans_s ans;
	logic [31:0] exp[2];
	logic [39:0] bad[9] = '{40'h02_0000_0002, 40'h03_0000_0000, 40'h03_0001_0000,
		40'h04_0000_0000, 40'h04_0000_03e9, 40'h05_0000_0004, 40'h08_0000_0000,
		40'h0d_0000_0000, 40'h0e_0000_0000};

	flow_data_accumulator #(.FAST_PERIOD(56), .SLOW_PERIOD(71), .NORMAL_PERIOD(NP)) i_dut (
		.clk(clk), .resetn(resetn), .singleHead(singleHead), .highSpeed(highSpeed),
		.filmMode(filmMode), .measIn(measIn), .hostReq(hostReq), .hostAns(hostAns),
		.item(item), .itemValid(itemValid), .itemLast(itemLast), .itemReady(itemReady),
		.bufferOverflow(bufferOverflow));
	host_model i_host (.clk(clk), .hostReq(hostReq), .hostAns(hostAns), .item(item),
		.itemValid(itemValid), .itemLast(itemLast), .itemReady(itemReady));

	initial forever #10 clk = ~clk;
	// Hang guard: about four times the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finalReport();
		end
	end

	task automatic check(input string what, input logic [31:0] e, s);
		nCompared++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] data, input logic [31:0] v, input logic e);
		i_host.send(CMD_PARAM_WRITE, 8'h00, FLOW_UNIT, data, v, ans);
		check("write err", {31'h0, e}, {31'h0, ans.err});
	endtask
	task automatic rd(input logic [7:0] unit, data, input logic [31:0] v);
		i_host.send(CMD_PARAM_READ, 8'h00, unit, data, 32'h0, ans);
		check("read data", v, ans.rdata);
	endtask
	task automatic req();
		i_host.send(CMD_AREA_READ, FLOW_AREA_CODE, 8'h00, 8'h00, 32'h1, ans);
		check("request err", 32'h0, {31'h0, ans.err});
	endtask
	// Waits for a batch of n items; lo/hi bound the wait for the first item,
	// gap is the exact distance from the previous batch's first item
	task automatic batch(input int n, input logic ovf, input int lo, input int hi,
		input int gap);
		int c0;
		c0 = cycles;
		while (!itemValid && cycles - c0 < 5000) @(negedge clk);
		if (hi > 0) check("first item time", 1, cycles - c0 >= lo && cycles - c0 <= hi);
		if (gap > 0) check("batch spacing", gap, cycles - tFirst);
		tFirst = cycles;
		while (i_host.got.size() < n && cycles - c0 < 8000) @(negedge clk);
		repeat (4) @(negedge clk);
		check("item count", n, i_host.got.size());
		for (int i = 0; i < i_host.got.size(); i++) begin
			check("header", {8'h0, ovf, measIn.microUnit, 11'h0, 1'b1, 10'h0},
				i_host.got[i].header);
			check("value", exp[i % 2], i_host.got[i].value);
			check("last flag", {31'h0, i == n - 1}, {31'h0, i_host.lastSeen[i]});
		end
		i_host.got.delete();
		i_host.lastSeen.delete();
	endtask

	task automatic finalReport();
		$display("compared %0d mismatches %0d", nCompared, fails);
		if (fails == 0 && nCompared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(32'h38a361ed));
		measIn = {$urandom, $urandom, $urandom, $urandom, 1'($urandom)};
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		// Power-up defaults, then cycle length against the enable
		for (int d = 2; d < 8; d++) rd(FLOW_UNIT, 8'(d), d == 3 || d == 4);
		rd(SYS_UNIT, DATA_CYCLE, FAST_CYCLE_US);
		wr(DATA_ENABLE, 32'h1, 1'b0);
		rd(SYS_UNIT, DATA_CYCLE, SLOW_CYCLE_US);
		wr(DATA_ENABLE, 32'h0, 1'b0);
		// Range limits, codes per mode, refusals that must store nothing
		wr(DATA_INTERVAL, 32'hffff, 1'b0);
		wr(DATA_DEPTH, 32'h3e8, 1'b0);
		for (int c = 0; c < 4; c++) wr(DATA_SLOT_FIRST, 32'(c), 1'b0);
		foreach (bad[i]) wr(bad[i][39:32], bad[i][31:0], 1'b1);
		rd(FLOW_UNIT, DATA_DEPTH, 32'h3e8);
		rd(FLOW_UNIT, DATA_INTERVAL, 32'hffff);
		i_host.send(CMD_AREA_READ, 8'h82, 8'h00, 8'h00, 32'h1, ans);
		check("area err", 32'h1, {31'h0, ans.err});
		filmMode = 1'b0;
		wr(DATA_SLOT_FIRST, 32'h2, 1'b1);
		wr(DATA_SLOT_FIRST, 32'h1, 1'b0);
		filmMode = 1'b1;
		singleHead = 1'b0;
		highSpeed = 1'b0;
		rd(SYS_UNIT, DATA_CYCLE, NORMAL_CYCLE_US);
		wr(8'h09, 32'h0, 1'b0);
		// Two slots active, one idle between them
		wr(DATA_INTERVAL, 32'h2, 1'b0);
		wr(DATA_DEPTH, 32'h3, 1'b0);
		wr(8'h05, 32'h3, 1'b0);
		wr(8'h06, 32'h0, 1'b0);
		wr(8'h07, 32'h1, 1'b0);
		exp = '{measIn.thickness, measIn.areaOne};
		// Request while disabled: nothing may come back yet
		req();
		repeat (3 * NP) @(negedge clk);
		check("early items", 32'h0, i_host.got.size());
		wr(DATA_ENABLE, 32'h1, 1'b0);
		batch(6, 1'b0, 6 * NP, 7 * NP + 40, 0);
		// Next request in time, slow sink; three stores of three cycles each apart
		i_host.slow = 1'b1;
		req();
		batch(6, 1'b0, 0, 0, 9 * NP);
		i_host.slow = 1'b0;
		// No request: batches pile up and overflow
		for (int k = 0; k < 4000 && bufferOverflow !== 1'b1; k++) @(negedge clk);
		check("overflow flag", 32'h1, {31'h0, bufferOverflow});
		rd(FLOW_UNIT, DATA_OVERFLOW, 32'h1);
		req();
		batch(6, 1'b1, 0, 0, 0);
		rd(FLOW_UNIT, DATA_OVERFLOW, 32'h0);
		// Disable drops the part-filled batch
		wr(DATA_ENABLE, 32'h0, 1'b0);
		req();
		repeat (4 * NP) @(negedge clk);
		check("items while off", 32'h0, i_host.got.size());
		// Second power-up in mid-run: every setting written above is lost
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		for (int d = 2; d < 8; d++) rd(FLOW_UNIT, 8'(d), d == 3 || d == 4);
		rd(SYS_UNIT, DATA_CYCLE, NORMAL_CYCLE_US);
		finalReport();
	end
endmodule

/* File: bench/host_model.sv */
// Host model: issues commands and drains the flow response stream.
// Assumes the bench calls send() and drives it on falling edges.
`timescale 1ns/1ps
module host_model
	import flow_acc_pkg::*;
(
	// Clock
	input logic clk,
	// Command port
	output host_req_s hostReq,
	input host_ans_s hostAns,
	// Flow stream
	input flow_item_s item,
	input logic itemValid,
	input logic itemLast,
	output logic itemReady
);
	logic slow = 1'b0;
	flow_item_s got[$];
	logic lastSeen[$];

	initial hostReq = '0;
	initial itemReady = 1'b1;
	// Random stalls when slow, so the device must hold each item
	always @(negedge clk) itemReady <= !slow || $urandom_range(1, 0) == 1;
	// Items are counted, never framed by a terminator value
	always @(posedge clk) if (itemValid && itemReady) begin
		got.push_back(item);
		lastSeen.push_back(itemLast);
	end

	// One-cycle request; idle fields scrambled so stale values never match
	task automatic send(input cmd_e kind, input logic [7:0] area, unit, data,
		input logic [31:0] wd, output host_ans_s ans);
		@(negedge clk);
		hostReq <= {1'b1, kind, area, unit, data, wd};
		@(negedge clk);
		ans = hostAns;
		hostReq <= {1'b0, ~hostReq[$bits(host_req_s)-2:0]};
	endtask
endmodule

/* File: include/flow_acc_pkg.sv */
// Shared constants and carriers for the flow data accumulator.
// Assumes a 50 MHz system clock and a host command decoder on the same clock.
package flow_acc_pkg;
	// Clock and measurement cycle timing
	localparam int CLK_MHZ = 50;
	localparam int FAST_CYCLE_US = 112;
	localparam int SLOW_CYCLE_US = 142;
	localparam int NORMAL_CYCLE_US = 250;
	localparam int FAST_CYCLES = FAST_CYCLE_US * CLK_MHZ;
	localparam int SLOW_CYCLES = SLOW_CYCLE_US * CLK_MHZ;
	localparam int NORMAL_CYCLES = NORMAL_CYCLE_US * CLK_MHZ;

	// Parameter map: unit and data numbers
	localparam logic [7:0] FLOW_UNIT = 8'h7c;
	localparam logic [7:0] DATA_ENABLE = 8'h02;
	localparam logic [7:0] DATA_INTERVAL = 8'h03;
	localparam logic [7:0] DATA_DEPTH = 8'h04;
	localparam logic [7:0] DATA_SLOT_FIRST = 8'h05;
	localparam logic [7:0] DATA_SLOT_LAST_SINGLE = 8'h07;
	localparam logic [7:0] DATA_SLOT_LAST = 8'h0d;
	localparam logic [7:0] DATA_OVERFLOW = 8'h0e;
	localparam logic [7:0] SYS_UNIT = 8'h00;
	localparam logic [7:0] DATA_CYCLE = 8'h02;
	localparam logic [7:0] FLOW_AREA_CODE = 8'he1;

	// Ranges and sizes
	localparam int MAX_SLOTS = 9;
	localparam int SINGLE_SLOTS = 3;
	localparam logic [31:0] MAX_DEPTH = 32'h0000_03e8;
	localparam logic [31:0] MAX_INTERVAL = 32'h0000_ffff;
	localparam int SLOT_W = 4;
	localparam int SAMPLE_W = 10;
	localparam int ADDR_W = 1 + SAMPLE_W + SLOT_W;
	localparam int MEM_WORDS = 1 << ADDR_W;
	localparam logic [SLOT_W-1:0] LAST_SLOT = 4'h8;

	// Reset values: nothing survives a power cycle
	localparam logic ENABLE_RST = 1'b0;
	localparam logic [15:0] INTERVAL_RST = 16'h0001;
	localparam logic [SAMPLE_W-1:0] DEPTH_RST = 10'h001;

	// Source codes
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_AREA_ONE = 2'h1;
	localparam logic [1:0] SRC_AREA_TWO = 2'h2;
	localparam logic [1:0] SRC_THICK = 2'h3;
	localparam logic [1:0] SRC_DISTANCE = 2'h1;

	// Item header bit positions
	localparam int HDR_OVFL_BIT = 23;
	localparam int HDR_UNIT_BIT = 22;
	localparam int HDR_STOP_BIT = 10;

	typedef enum logic [1:0] {CMD_NONE, CMD_PARAM_READ, CMD_PARAM_WRITE, CMD_AREA_READ} cmd_e;

	typedef struct packed {
		logic valid;
		cmd_e kind;
		logic [7:0] areaCode;
		logic [7:0] unitNo;
		logic [7:0] dataNo;
		logic [31:0] wdata;
	} host_req_s;

	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} host_ans_s;

	typedef struct packed {
		logic [31:0] header;
		logic [31:0] value;
	} flow_item_s;

	typedef struct packed {
		logic [31:0] areaOne;
		logic [31:0] areaTwo;
		logic [31:0] thickness;
		logic [31:0] distance;
		logic microUnit;
	} meas_s;
endpackage

/* File: rtl/batch_sender.sv */
// Walks one completed batch out of the buffer as response items.
// Assumes a buffer with one cycle of read latency driven by the parent.
`timescale 1ns/1ps
module batch_sender
	import flow_acc_pkg::*;
(
	// Clock and reset
	input logic clk,
	input logic resetn,
	// Batch handed over
	input logic start,
	input logic startBank,
	input logic [SAMPLE_W-1:0] depth,
	input logic [MAX_SLOTS-1:0] slotOn,
	input logic overflowIn,
	// Buffer read side
	input logic [32:0] rdData,
	output logic [ADDR_W-1:0] rdAddr,
	// Response stream
	output flow_item_s item,
	output logic itemValid,
	output logic itemLast,
	input logic itemReady,
	output logic busy
);
	typedef enum logic [1:0] {S_IDLE, S_SEEK, S_READ, S_SHOW} send_e;
	send_e state_reg;
	logic bank_reg;
	logic ovfl_reg;
	logic [SAMPLE_W-1:0] sample_reg;
	logic [SLOT_W-1:0] slot_reg;
	logic [SLOT_W-1:0] hiSlot;
	logic lastNow;

	// Highest enabled slot ends the last sample row, and so the batch
	always_comb begin
		hiSlot = 4'h0;
		for (int i = 0; i < MAX_SLOTS; i++) begin
			if (slotOn[i]) hiSlot = SLOT_W'(i);
		end
	end

	assign rdAddr = {bank_reg, sample_reg, slot_reg};
	assign lastNow = (sample_reg == depth - 10'h001) && (slot_reg == hiSlot);
	assign busy = (state_reg != S_IDLE);

	// Item sequencer; stalls on itemReady
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= S_IDLE;
			bank_reg <= 1'b0;
			ovfl_reg <= 1'b0;
			sample_reg <= 10'h000;
			slot_reg <= 4'h0;
			item <= '0;
			itemValid <= 1'b0;
			itemLast <= 1'b0;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					if (start) begin
						bank_reg <= startBank;
						ovfl_reg <= overflowIn;
						sample_reg <= 10'h000;
						slot_reg <= 4'h0;
						state_reg <= S_SEEK;
					end
				end
				S_SEEK: begin
					if (slotOn[slot_reg]) begin
						state_reg <= S_READ;
					end else if (slot_reg == LAST_SLOT) begin
						slot_reg <= 4'h0;
						sample_reg <= sample_reg + 10'h001;
					end else begin
						slot_reg <= slot_reg + 4'h1;
					end
				end
				S_READ: begin
					item.value <= rdData[31:0];
					item.header <= 32'h0;
					item.header[HDR_UNIT_BIT] <= rdData[32];
					item.header[HDR_OVFL_BIT] <= ovfl_reg;
					item.header[HDR_STOP_BIT] <= 1'b1;
					itemValid <= 1'b1;
					itemLast <= lastNow;
					state_reg <= S_SHOW;
				end
				S_SHOW: begin
					if (itemReady) begin
						itemValid <= 1'b0;
						itemLast <= 1'b0;
						if (itemLast) begin
							state_reg <= S_IDLE;
						end else begin
							state_reg <= S_SEEK;
							if (slot_reg == LAST_SLOT) begin
								slot_reg <= 4'h0;
								sample_reg <= sample_reg + 10'h001;
							end else begin
								slot_reg <= slot_reg + 4'h1;
							end
						end
					end
				end
			endcase
		end
	end
endmodule

/* File: rtl/flow_data_accumulator.sv */
// Flow data accumulator: decimates measurement results into a batch
// buffer and returns a completed batch as one response when requested.
// Assumes a host command decoder and measurement logic on clk.
`timescale 1ns/1ps
module flow_data_accumulator
	import flow_acc_pkg::*;
#(
	parameter int FAST_PERIOD = FAST_CYCLES,
	parameter int SLOW_PERIOD = SLOW_CYCLES,
	parameter int NORMAL_PERIOD = NORMAL_CYCLES
) (
	// Clock and reset
	input logic clk,
	input logic resetn,
	// Variant and mode
	input logic singleHead,
	input logic highSpeed,
	input logic filmMode,
	// Live measurement results
	input meas_s measIn,
	// Host command port
	input host_req_s hostReq,
	output host_ans_s hostAns,
	// Flow response stream
	output flow_item_s item,
	output logic itemValid,
	output logic itemLast,
	input logic itemReady,
	// Buffer overflow error flag
	output logic bufferOverflow
);
	typedef enum logic {CAP_IDLE, CAP_WRITE} cap_e;

	// Settings
	logic enable_reg;
	logic [15:0] interval_reg;
	logic [SAMPLE_W-1:0] depth_reg;
	logic [MAX_SLOTS-1:0][1:0] slotCode_reg;
	// Accumulation state
	cap_e cap_reg;
	logic [15:0] skip_reg;
	logic [SAMPLE_W-1:0] sample_reg;
	logic [SLOT_W-1:0] wrSlot_reg;
	meas_s snap_reg;
	logic fillBank_reg;
	logic fullBank_reg;
	logic fullValid_reg;
	logic pending_reg;
	logic ovfl_reg;
	host_ans_s ans_reg;
	// Buffer
	logic [32:0] batchMem [0:MEM_WORDS-1];
	logic [32:0] rdData;
	logic [ADDR_W-1:0] rdAddr;

	// Command decode
	logic isFlowUnit;
	logic isRead;
	logic isWrite;
	logic [7:0] slotLastNo;
	logic [7:0] slotOff;
	logic [SLOT_W-1:0] slotIdx;
	logic isSlot;
	logic [1:0] maxCode;
	logic isCycle;
	logic wrEnable;
	logic wrInterval;
	logic wrDepth;
	logic wrSlot;
	logic rdOk;
	logic flowReq;
	logic [31:0] rdMux;

	assign isFlowUnit = (hostReq.unitNo == FLOW_UNIT);
	assign isRead = hostReq.valid && (hostReq.kind == CMD_PARAM_READ);
	assign isWrite = hostReq.valid && (hostReq.kind == CMD_PARAM_WRITE);
	assign slotLastNo = singleHead ? DATA_SLOT_LAST_SINGLE : DATA_SLOT_LAST;
	assign slotOff = hostReq.dataNo - DATA_SLOT_FIRST;
	assign slotIdx = slotOff[SLOT_W-1:0];
	assign isSlot = isFlowUnit && (hostReq.dataNo >= DATA_SLOT_FIRST)
		&& (hostReq.dataNo <= slotLastNo);
	assign maxCode = filmMode ? SRC_THICK : SRC_DISTANCE;
	assign isCycle = (hostReq.unitNo == SYS_UNIT) && (hostReq.dataNo == DATA_CYCLE);

	// Out-of-range writes are refused and leave the setting alone
	assign wrEnable = isWrite && isFlowUnit && (hostReq.dataNo == DATA_ENABLE)
		&& (hostReq.wdata[31:1] == 31'h0);
	assign wrInterval = isWrite && isFlowUnit && (hostReq.dataNo == DATA_INTERVAL)
		&& (hostReq.wdata != 32'h0) && (hostReq.wdata <= MAX_INTERVAL);
	assign wrDepth = isWrite && isFlowUnit && (hostReq.dataNo == DATA_DEPTH)
		&& (hostReq.wdata != 32'h0) && (hostReq.wdata <= MAX_DEPTH);
	assign wrSlot = isWrite && isSlot && (hostReq.wdata <= {30'h0, maxCode});
	assign flowReq = hostReq.valid && (hostReq.kind == CMD_AREA_READ)
		&& (hostReq.areaCode == FLOW_AREA_CODE);

	// Measurement cycle selection
	logic slowMode;
	logic [15:0] period;
	logic [15:0] cycleUs;
	logic tick;

	assign slowMode = singleHead && highSpeed;
	assign period = !slowMode ? 16'(NORMAL_PERIOD)
		: (enable_reg ? 16'(SLOW_PERIOD) : 16'(FAST_PERIOD));
	assign cycleUs = !slowMode ? 16'(NORMAL_CYCLE_US)
		: (enable_reg ? 16'(SLOW_CYCLE_US) : 16'(FAST_CYCLE_US));

	meas_cycle_timer cycleTimer (
		.clk(clk),
		.resetn(resetn),
		.period(period),
		.tick(tick)
	);

	// Read mux over the parameter map
	always_comb begin
		rdOk = 1'b0;
		rdMux = 32'h0;
		if (isRead && isSlot) begin
			rdOk = 1'b1;
			rdMux = {30'h0, slotCode_reg[slotIdx]};
		end else if (isRead && isCycle) begin
			rdOk = 1'b1;
			rdMux = {16'h0, cycleUs};
		end else if (isRead && isFlowUnit) begin
			rdOk = 1'b1;
			unique case (hostReq.dataNo)
				DATA_ENABLE: rdMux = {31'h0, enable_reg};
				DATA_INTERVAL: rdMux = {16'h0, interval_reg};
				DATA_DEPTH: rdMux = {22'h0, depth_reg};
				DATA_OVERFLOW: rdMux = {31'h0, ovfl_reg};
				default: rdOk = 1'b0;
			endcase
		end
	end

	// Slot enables: a code that the present mode does not know is none
	logic [MAX_SLOTS-1:0] slotOn;
	logic anyOn;
	genvar g;
	generate
		for (g = 0; g < MAX_SLOTS; g++) begin : slotGen
			assign slotOn[g] = (slotCode_reg[g] != SRC_NONE) && (slotCode_reg[g] <= maxCode)
				&& (!singleHead || (g < SINGLE_SLOTS));
		end
	endgenerate
	assign anyOn = |slotOn;

	// Source pick for one slot
	function automatic logic [31:0] pickValue(input logic [1:0] code, input logic film,
		input meas_s m);
		logic [31:0] v;
		v = 32'h0;
		if (film) begin
			if (code == SRC_AREA_ONE) v = m.areaOne;
			if (code == SRC_AREA_TWO) v = m.areaTwo;
			if (code == SRC_THICK) v = m.thickness;
		end else if (code == SRC_DISTANCE) begin
			v = m.distance;
		end
		return v;
	endfunction

	// Sampling and completion events
	logic storeNow;
	logic rowDone;
	logic batchDone;
	logic senderBusy;
	logic startSend;
	logic overflowEvt;
	logic memWe;
	logic [ADDR_W-1:0] wrAddr;
	logic [32:0] wrWord;

	assign storeNow = tick && enable_reg && anyOn && (cap_reg == CAP_IDLE)
		&& (skip_reg == 16'h0000);
	assign rowDone = (cap_reg == CAP_WRITE) && (wrSlot_reg == LAST_SLOT);
	assign batchDone = rowDone && (sample_reg == depth_reg - 10'h001);
	// Full batch still unclaimed, or the other bank still being sent
	assign overflowEvt = batchDone && (fullValid_reg || senderBusy);
	assign startSend = pending_reg && fullValid_reg && !senderBusy && !batchDone;
	assign memWe = (cap_reg == CAP_WRITE) && slotOn[wrSlot_reg];
	assign wrAddr = {fillBank_reg, sample_reg, wrSlot_reg};
	assign wrWord = {snap_reg.microUnit, pickValue(slotCode_reg[wrSlot_reg], filmMode, snap_reg)};

	// Batch buffer, two banks
	always_ff @(posedge clk) begin
		if (memWe) batchMem[wrAddr] <= wrWord;
		rdData <= batchMem[rdAddr];
	end

	// Settings, volatile across reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			enable_reg <= ENABLE_RST;
			interval_reg <= INTERVAL_RST;
			depth_reg <= DEPTH_RST;
			slotCode_reg <= '0;
		end else begin
			if (wrEnable) enable_reg <= hostReq.wdata[0];
			if (wrInterval) interval_reg <= hostReq.wdata[15:0];
			if (wrDepth) depth_reg <= hostReq.wdata[SAMPLE_W-1:0];
			if (wrSlot) slotCode_reg[slotIdx] <= hostReq.wdata[1:0];
		end
	end

	// Command answer, one cycle after the request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ans_reg <= '0;
		end else begin
			ans_reg.ack <= hostReq.valid;
			ans_reg.err <= hostReq.valid
				&& !(wrEnable || wrInterval || wrDepth || wrSlot || rdOk || flowReq);
			ans_reg.rdata <= rdOk ? rdMux : 32'h0;
		end
	end
	assign hostAns = ans_reg;

	// Skip and sample counters with the slot write walk
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cap_reg <= CAP_IDLE;
			skip_reg <= 16'h0000;
			sample_reg <= 10'h000;
			wrSlot_reg <= 4'h0;
			snap_reg <= '0;
		end else if (!enable_reg) begin
			cap_reg <= CAP_IDLE;
			skip_reg <= 16'h0000;
			sample_reg <= 10'h000;
			wrSlot_reg <= 4'h0;
		end else begin
			unique case (cap_reg)
				CAP_IDLE: begin
					if (storeNow) begin
						snap_reg <= measIn;
						skip_reg <= interval_reg;
						wrSlot_reg <= 4'h0;
						cap_reg <= CAP_WRITE;
					end else if (tick && anyOn && (skip_reg != 16'h0000)) begin
						skip_reg <= skip_reg - 16'h0001;
					end
				end
				CAP_WRITE: begin
					if (rowDone) begin
						cap_reg <= CAP_IDLE;
						wrSlot_reg <= 4'h0;
						// Skip count is kept, so the next sample stays on schedule
						sample_reg <= batchDone ? 10'h000 : sample_reg + 10'h001;
					end else begin
						wrSlot_reg <= wrSlot_reg + 4'h1;
					end
				end
			endcase
		end
	end

	// Bank handover, pending request and overflow flag
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fillBank_reg <= 1'b0;
			fullBank_reg <= 1'b1;
			fullValid_reg <= 1'b0;
			pending_reg <= 1'b0;
			ovfl_reg <= 1'b0;
		end else begin
			// A request in the start cycle stays pending for the next batch
			if (flowReq) pending_reg <= 1'b1;
			else if (startSend) pending_reg <= 1'b0;
			if (!enable_reg) begin
				fullValid_reg <= 1'b0;
			end else if (batchDone && !senderBusy) begin
				fullBank_reg <= fillBank_reg;
				fillBank_reg <= !fillBank_reg;
				fullValid_reg <= 1'b1;
			end else if (startSend) begin
				fullValid_reg <= 1'b0;
			end
			// Overflow set wins over the clear taken by a starting response
			if (overflowEvt) ovfl_reg <= 1'b1;
			else if (startSend) ovfl_reg <= 1'b0;
		end
	end
	assign bufferOverflow = ovfl_reg;

	batch_sender sender (
		.clk(clk),
		.resetn(resetn),
		.start(startSend),
		.startBank(fullBank_reg),
		.depth(depth_reg),
		.slotOn(slotOn),
		.overflowIn(ovfl_reg),
		.rdData(rdData),
		.rdAddr(rdAddr),
		.item(item),
		.itemValid(itemValid),
		.itemLast(itemLast),
		.itemReady(itemReady),
		.busy(senderBusy)
	);
endmodule

/* File: rtl/meas_cycle_timer.sv */
// Measurement cycle tick generator.
// Assumes the period input changes only between settings writes.
`timescale 1ns/1ps
module meas_cycle_timer
	import flow_acc_pkg::*;
(
	// Clock and reset
	input logic clk,
	input logic resetn,
	// Period in clocks
	input logic [15:0] period,
	// One pulse per measurement cycle
	output logic tick
);
	logic [15:0] cnt_reg;
	logic [15:0] lastPeriod_reg;
	logic wrap;
	logic changed;

	// A period change restarts the count, so no cycle runs short
	assign wrap = (cnt_reg == period - 16'h0001);
	assign changed = (lastPeriod_reg != period);

	// Free-running cycle counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= 16'h0000;
			lastPeriod_reg <= 16'h0000;
			tick <= 1'b0;
		end else begin
			lastPeriod_reg <= period;
			tick <= wrap && !changed;
			cnt_reg <= (wrap || changed) ? 16'h0000 : cnt_reg + 16'h0001;
		end
	end
endmodule
